// >>> frtc_counter.sv
module frtc_counter
	import frtc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       tick,
	input  wire logic       reload,
	// Count out
	output frtc_cnt_t       cnt
);

	typedef struct packed {
		logic [15:0] count;
	} frtc_cnt_st_t;

	frtc_cnt_st_t st_r;
	frtc_cnt_st_t st_nxt;

	// ---------------------------------------------------------------
	// Free-running up-counter
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (reload) begin
			st_nxt.count = COUNT_RESET;
		end else if (tick) begin
			st_nxt.count = st_r.count + 16'h0001;
		end
		cnt.count = st_r.count;
		cnt.tick  = tick;
		cnt.ovf   = tick && !reload && (st_r.count == COUNT_TOP);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.count <= COUNT_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // frtc_counter

// >>> frtc_pkg.sv
package frtc_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h00;
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h04;
	localparam logic [7:0] ADDR_ALT_HIGH   = 8'h08;
	localparam logic [7:0] ADDR_ALT_LOW    = 8'h0c;
	localparam logic [7:0] ADDR_STATUS     = 8'h10;
	localparam logic [7:0] ADDR_CTRL_ONE   = 8'h14;
	localparam logic [7:0] ADDR_CTRL_TWO   = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1c;
	localparam logic [7:0] ADDR_POWER      = 8'h20;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int         OVF_BIT         = 7;
	localparam int         OVF_IE_BIT      = 5;
	localparam logic [1:0] CS_DIV4         = 2'h0;
	localparam logic [1:0] CS_DIV2         = 2'h1;
	localparam logic [1:0] CS_DIV8         = 2'h2;
	localparam logic [1:0] CS_EXT          = 2'h3;
	localparam logic [15:0] COUNT_RESET    = 16'hfffc;
	localparam logic [15:0] COUNT_TOP      = 16'hffff;
	localparam logic [7:0] CTRL_TWO_RESET  = 8'h00;
	localparam logic [7:0] MASK_RESET      = 8'h00;
	localparam logic [2:0] PRESC_MAX       = 3'h7;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} frtc_acc_t;

	typedef struct packed {
		logic       tick;
		logic       ovf;
		logic [15:0] count;
	} frtc_cnt_t;

endpackage

// >>> frtc_prescaler.sv
module frtc_prescaler
	import frtc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic [1:0] clock_select_field,
	input  wire logic       run,
	input  wire logic       ext_tick,
	// Tick out
	output logic            tick
);

	typedef struct packed {
		logic [2:0] div;
	} frtc_presc_st_t;

	frtc_presc_st_t st_r;
	frtc_presc_st_t st_nxt;

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	// The divider holds while halted so counting resumes in phase.
	always_comb begin
		st_nxt = st_r;
		if (run) begin
			st_nxt.div = st_r.div + 3'h1;
		end
		unique case (clock_select_field)
			CS_DIV2: tick = run && st_r.div[0];
			CS_DIV4: tick = run && (st_r.div[1:0] == 2'h3);
			CS_DIV8: tick = run && (st_r.div == PRESC_MAX);
			CS_EXT:  tick = run && ext_tick;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // frtc_prescaler

// >>> frtc_timer.sv
// Functional notes
// - Sixteen-bit up-counter advancing once per prescaled timer tick.
// - Two-bit clock select: divide by 2, 4, 8 or external tick.
// - Two identical count views, high bytes read-only; alternate low read keeps overflow flag.
// - Writing either low byte reloads the counter with fffc.
// - Reset starts the counter at fffc, its only load value.
// - High byte read first latches the matching low byte.
// - Latched low byte holds until the sequence ends, despite repeated high reads.
// - Outside a sequence, low byte reads return the live low byte.
// - Rollover from ffff to 0000 sets the overflow flag.
// - Overflow interrupt requested if enabled and global mask clear, else pending; irq_status bits set in irq_mask also raise timer_irq.
// - Overflow flag clears after status read then normal low byte access.
// - Counting continues normally in wait mode.
// - Halt stops counting; wake by interrupt resumes, reset restarts.
module frtc_timer
	import frtc_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU side
	input  wire logic        cpu_int_mask,
	input  wire logic        cpu_wait,
	input  wire logic        cpu_halt,
	input  wire logic        ext_tick,
	// Interrupt
	output logic             timer_irq
);

	typedef struct packed {
		logic [7:0]  low_latch;
		logic        seq_open;
		logic        ovf_armed;
		logic        overflow_flag;
		logic        overflow_interrupt_enable;
		logic [7:0]  timer_control_two;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [31:0] rdata;
	} frtc_st_t;

	frtc_st_t   st_r;
	frtc_st_t   st_nxt;
	frtc_acc_t  acc;
	frtc_cnt_t  cnt;
	logic       tick;
	logic       run;
	logic       reload;
	logic       mapped;

	function automatic logic hit(input frtc_acc_t a, input logic [7:0] ad);
		hit = (a.rd || a.wr) && (a.addr == ad);
	endfunction

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// Every access completes in its first access cycle; no wait states.
	// Reads are decoded in the setup cycle so that their registered data stand
	// through the access cycle. The access cycle always follows the setup cycle,
	// so read side effects taken here are never abandoned.
	always_comb begin
		acc.wr    = psel && penable && pwrite;
		acc.rd    = psel && !penable && !pwrite;
		acc.addr  = paddr;
		acc.wdata = pwdata[7:0];
		unique case (paddr)
			ADDR_COUNT_HIGH, ADDR_COUNT_LOW, ADDR_ALT_HIGH, ADDR_ALT_LOW,
			ADDR_STATUS, ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_IRQ_MASK,
			ADDR_POWER: mapped = 1'b1;
			default:    mapped = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = st_r.rdata;

	// Wait mode does not gate the timer; only halt freezes it.
	assign run    = !cpu_halt || cpu_wait && 1'b0;
	assign reload = acc.wr && (hit(acc, ADDR_COUNT_LOW) || hit(acc, ADDR_ALT_LOW));

	// ---------------------------------------------------------------
	// Sub-blocks
	// ---------------------------------------------------------------
	frtc_prescaler u_presc (
		.core_clk           (core_clk),
		.rst_n              (rst_n),
		.clock_select_field (st_r.timer_control_two[1:0]),
		.run                (run),
		.ext_tick           (ext_tick),
		.tick               (tick)
	);

	frtc_counter u_count (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (tick),
		.reload   (reload),
		.cnt      (cnt)
	);

	// ---------------------------------------------------------------
	// Register file and read sequence
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 32'h0000_0000;

		if (acc.rd) begin
			unique case (acc.addr)
				ADDR_COUNT_HIGH, ADDR_ALT_HIGH: begin
					st_nxt.rdata[7:0] = cnt.count[15:8];
					if (!st_r.seq_open) begin
						st_nxt.low_latch = cnt.count[7:0];
						st_nxt.seq_open  = 1'b1;
					end
				end
				ADDR_COUNT_LOW, ADDR_ALT_LOW: begin
					if (st_r.seq_open) begin
						st_nxt.rdata[7:0] = st_r.low_latch;
						st_nxt.seq_open   = 1'b0;
					end else begin
						st_nxt.rdata[7:0] = cnt.count[7:0];
					end
				end
				ADDR_STATUS: begin
					st_nxt.rdata[OVF_BIT] = st_r.overflow_flag;
					if (st_r.overflow_flag) begin
						st_nxt.ovf_armed = 1'b1;
					end
				end
				ADDR_CTRL_ONE: begin
					st_nxt.rdata[OVF_IE_BIT] = st_r.overflow_interrupt_enable;
				end
				ADDR_CTRL_TWO: st_nxt.rdata[7:0] = st_r.timer_control_two;
				ADDR_IRQ_MASK: st_nxt.rdata[1:0] = st_r.irq_mask;
				ADDR_POWER:    st_nxt.rdata[1:0] = st_r.irq_status;
				default:       st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		if (acc.wr) begin
			unique case (acc.addr)
				ADDR_CTRL_ONE: begin
					st_nxt.overflow_interrupt_enable = acc.wdata[OVF_IE_BIT];
				end
				ADDR_CTRL_TWO: st_nxt.timer_control_two = acc.wdata;
				ADDR_IRQ_MASK: st_nxt.irq_mask = acc.wdata[1:0];
				ADDR_POWER:    st_nxt.irq_status = st_r.irq_status & ~acc.wdata[1:0];
				default:       st_nxt.irq_mask = st_nxt.irq_mask;
			endcase
		end

		// Only the normal low byte completes the clear; the alternate one never does.
		if (st_r.ovf_armed && hit(acc, ADDR_COUNT_LOW)) begin
			st_nxt.overflow_flag = 1'b0;
			st_nxt.ovf_armed     = 1'b0;
		end

		// A rollover in the clearing cycle keeps the flag set.
		if (cnt.ovf) begin
			st_nxt.overflow_flag = 1'b1;
			st_nxt.irq_status[0] = 1'b1;
		end
		if (reload) begin
			st_nxt.irq_status[1] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.low_latch                 <= 8'h00;
			st_r.seq_open                  <= 1'b0;
			st_r.ovf_armed                 <= 1'b0;
			st_r.overflow_flag             <= 1'b0;
			st_r.overflow_interrupt_enable <= 1'b0;
			st_r.timer_control_two         <= CTRL_TWO_RESET;
			st_r.irq_status                <= 2'h0;
			st_r.irq_mask                  <= 2'h0;
			st_r.rdata                     <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------
	// The request stays pending in the flag until enable and mask allow it.
	always_comb begin
		timer_irq = (st_r.overflow_flag && st_r.overflow_interrupt_enable
			&& !cpu_int_mask)
			|| (|(st_r.irq_status & st_r.irq_mask));
	end

endmodule // frtc_timer

// >>> frtc_timer_properties.sv
module frtc_timer_properties
	import frtc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cpu_int_mask,
	input wire logic        cpu_wait,
	input wire logic        cpu_halt,
	input wire logic        ext_tick,
	input wire logic        timer_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic rd_acc;
	// Reads are decoded in the setup cycle; their data stand in the access cycle.
	assign rd_acc = psel && !penable && !pwrite;
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err_phase; pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
	property p_err_addr; psel && penable && paddr == 8'h24 |-> pslverr; endproperty
	a_err_addr: assert property (p_err_addr) else $error("no pslverr on hole");
	property p_rd_upper; prdata[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("prdata upper set");
	property p_rd_idle; !rd_acc |=> prdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("prdata stale");
	property p_rd_hole; rd_acc && paddr == 8'h24 |=> prdata == 32'h0; endproperty
	a_rd_hole: assert property (p_rd_hole) else $error("hole read nonzero");
	property p_stat; rd_acc && paddr == ADDR_STATUS |=> prdata[6:0] == 7'h0; endproperty
	a_stat: assert property (p_stat) else $error("status spare bits");
	property p_irq_rst; $rose(rst_n) |-> !timer_irq; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
	c_ovf: cover property (rd_acc && paddr == ADDR_STATUS ##1 prdata[OVF_BIT]);
	c_irq: cover property ($rose(timer_irq));
	c_err: cover property (pslverr);
endmodule // frtc_timer_properties

bind frtc_timer frtc_timer_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_int_mask(cpu_int_mask),
	.cpu_wait(cpu_wait), .cpu_halt(cpu_halt), .ext_tick(ext_tick), .timer_irq(timer_irq));

// >>> frtc_timer_tb.sv
module frtc_timer_tb
	import frtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cpu_int_mask = 1'b1;
	logic        cpu_wait = 1'b0;
	logic        cpu_halt = 1'b1;
	logic        ext_tick = 1'b0;
	logic        timer_irq;
	logic [31:0] rd;
	logic        err;
	logic [15:0] v;
	logic [1:0]  cs_tab [3] = '{CS_DIV2, CS_DIV4, CS_DIV8};
	int          failures = 0;
	int          n_tests = 0;

	always #20 core_clk = ~core_clk;

	frtc_timer DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_int_mask(cpu_int_mask), .cpu_wait(cpu_wait),
		.cpu_halt(cpu_halt), .ext_tick(ext_tick), .timer_irq(timer_irq));

	// Read data stand through the access cycle and are taken at the edge that ends it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	task automatic irqchk(input logic exp);
		#1 chk("timer_irq", {31'h0, exp}, {31'h0, timer_irq});
		@(posedge core_clk);
	endtask

	// External ticks are spaced so that each one is a separate count.
	task automatic ticks(input int n);
		repeat (n) begin
			ext_tick <= 1'b1;
			@(posedge core_clk);
			ext_tick <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#400000;
		failures++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdchk("count high", ADDR_COUNT_HIGH, 32'hff);
		rdchk("count low", ADDR_COUNT_LOW, 32'hfc);
		rdchk("ctrl two", ADDR_CTRL_TWO, {24'h0, CTRL_TWO_RESET});
		apb(1'b0, 8'h24, 32'h0);
		chk("hole err", 32'h1, {31'h0, err});
		chk("hole data", 32'h0, rd);
		$display("test reset done");
		apb(1'b1, ADDR_CTRL_TWO, {30'h0, CS_EXT});
		cpu_halt <= 1'b0;
		apb(1'b1, ADDR_COUNT_LOW, 32'h0);
		rdchk("high first", ADDR_COUNT_HIGH, 32'hff);
		ticks(2);
		rdchk("high again", ADDR_COUNT_HIGH, 32'hff);
		rdchk("latched low", ADDR_COUNT_LOW, 32'hfc);
		rdchk("live low", ADDR_COUNT_LOW, 32'hfe);
		ticks(2);
		rdchk("alt low", ADDR_ALT_LOW, 32'h0);
		rdchk("low unarmed", ADDR_COUNT_LOW, 32'h0);
		rdchk("status", ADDR_STATUS, 32'h1 << OVF_BIT);
		apb(1'b1, ADDR_CTRL_ONE, 32'h1 << OVF_IE_BIT);
		irqchk(1'b0);
		cpu_int_mask <= 1'b0;
		@(posedge core_clk);
		irqchk(1'b1);
		rdchk("alt armed", ADDR_ALT_LOW, 32'h0);
		rdchk("status kept", ADDR_STATUS, 32'h1 << OVF_BIT);
		rdchk("low clears", ADDR_COUNT_LOW, 32'h0);
		rdchk("status clear", ADDR_STATUS, 32'h0);
		irqchk(1'b0);
		$display("test sequence done");
		cpu_wait <= 1'b1;
		ticks(3);
		rdchk("wait count", ADDR_COUNT_LOW, 32'h3);
		cpu_halt <= 1'b1;
		ticks(3);
		rdchk("halt count", ADDR_COUNT_LOW, 32'h3);
		cpu_halt <= 1'b0;
		cpu_wait <= 1'b0;
		ticks(1);
		rdchk("resumed", ADDR_COUNT_LOW, 32'h4);
		apb(1'b1, ADDR_ALT_LOW, 32'h0);
		rdchk("alt reload", ADDR_ALT_LOW, 32'hfc);
		$display("test power done");
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		apb(1'b1, ADDR_COUNT_LOW, 32'h0);
		irqchk(1'b0);
		rdchk("sticky", ADDR_POWER, 32'h3);
		apb(1'b1, ADDR_IRQ_MASK, 32'h2);
		irqchk(1'b1);
		apb(1'b1, ADDR_POWER, 32'h2);
		irqchk(1'b0);
		rdchk("sticky clr", ADDR_POWER, 32'h1);
		$display("test irq done");
		for (int i = 0; i < 3; i++) begin
			cpu_halt <= 1'b1;
			apb(1'b1, ADDR_CTRL_TWO, {30'h0, cs_tab[i]});
			apb(1'b1, ADDR_COUNT_LOW, 32'h0);
			cpu_halt <= 1'b0;
			repeat (64) @(posedge core_clk);
			cpu_halt <= 1'b1;
			apb(1'b0, ADDR_COUNT_HIGH, 32'h0);
			v[15:8] = rd[7:0];
			apb(1'b0, ADDR_COUNT_LOW, 32'h0);
			v[7:0] = rd[7:0];
			v = v - COUNT_RESET;
			chk("ticks", 32'h1, {31'h0, v >= 16'(31 >> i) && v <= 16'(33 >> i)});
		end
		$display("test prescaler done");
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdchk("reset wake high", ADDR_COUNT_HIGH, 32'hff);
		rdchk("reset wake low", ADDR_COUNT_LOW, 32'hfc);
		$display("test reset wake done");
		give_verdict();
	end
endmodule // frtc_timer_tb
